// File: shared/pacc_pkg.sv
package pacc_pkg;

    // ----------------------------------------
    // register map (index, byte address = 4 * index)
    // ----------------------------------------
    localparam int         ADDR_W       = 10;
    localparam logic [7:0] IDX_CAP      = 8'h59;
    localparam logic [7:0] IDX_POW      = 8'h5A;
    localparam logic [7:0] IDX_STAT     = 8'h5B;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int         CAP_REQ_BIT  = 7;
    localparam int         CAP_DIS_BIT  = 6;
    localparam int         POW_DIS_BIT  = 6;
    localparam int         CUR_LSB      = 4;
    localparam int         GAIN_LSB     = 0;
    localparam int         STAT_BUSY    = 0;
    localparam int         STAT_DONE    = 1;
    localparam int         STAT_HOLD    = 2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CAP_RST      = 8'h00;
    localparam logic [7:0] POW_RST      = 8'h00;

    // ----------------------------------------
    // analogue scaling
    // ----------------------------------------
    // capacitor step 0.3 pF = 300 fF
    localparam logic [8:0]  CAP_STEP_FF  = 9'h12C;
    // amplifier current in microamps per code
    localparam logic [11:0] CUR_UA_0     = 12'hFA0;
    localparam logic [11:0] CUR_UA_1     = 12'h7D0;
    localparam logic [11:0] CUR_UA_2     = 12'h3E8;
    localparam logic [11:0] CUR_UA_3     = 12'h1F4;
    // output level in hundredths of dBuV: 124 minus 1.5 per step
    localparam logic [15:0] LEVEL_TOP    = 16'h3070;
    localparam logic [15:0] LEVEL_STEP   = 16'h0096;

    // ----------------------------------------
    // calibration sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        pacc_idle,
        pacc_hold,
        pacc_run
    } pacc_seq_type;

endpackage

// File: src/pacc_cal_seq.sv
`timescale 1ns/1ps
module pacc_cal_seq #(
    parameter int CAP_W  = 6,
    parameter int CUR_W  = 2,
    parameter int GAIN_W = 4
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // request level from the register bank
    input  wire logic              req,
    // calibration engine
    input  wire logic              cal_done,
    input  wire logic [CAP_W-1:0]  cal_cap_result,
    input  wire logic [CUR_W-1:0]  cal_current_result,
    input  wire logic [GAIN_W-1:0] cal_gain_result,
    output logic                   cal_hold,
    output logic                   cal_start,
    // status and stored results
    output logic                   busy,
    output logic                   done,
    output logic [CAP_W-1:0]       res_cap,
    output logic [CUR_W-1:0]       res_cur,
    output logic [GAIN_W-1:0]      res_gain
);

    typedef struct packed {
        pacc_pkg::pacc_seq_type state;
        logic                   req_d;
        logic                   start;
        logic                   done;
        logic [CAP_W-1:0]       cap;
        logic [CUR_W-1:0]       cur;
        logic [GAIN_W-1:0]      gain;
    } pacc_seq_st_type;

    pacc_seq_st_type s;
    pacc_seq_st_type next_s;
    logic            done_set;

    always_comb begin
        next_s = s;
        next_s.req_d = req;
        next_s.start = 1'b0;
        done_set = (s.state == pacc_pkg::pacc_run) && cal_done;
        // results land even if an abort races them, so no finished run is lost
        if (done_set) begin
            next_s.cap = cal_cap_result;
            next_s.cur = cal_current_result;
            next_s.gain = cal_gain_result;
        end
        // a completed run sets done over a clear in the same cycle
        next_s.done = done_set | (s.done & ~req);
        if (req) begin
            next_s.state = pacc_pkg::pacc_hold;
        end else if (s.req_d) begin
            next_s.state = pacc_pkg::pacc_run;
            next_s.start = 1'b1;
        end else begin
            unique case (s.state)
                pacc_pkg::pacc_idle: next_s.state = pacc_pkg::pacc_idle;
                pacc_pkg::pacc_hold: next_s.state = pacc_pkg::pacc_idle;
                pacc_pkg::pacc_run: begin
                    if (cal_done) begin
                        next_s.state = pacc_pkg::pacc_idle;
                    end
                end
                default: next_s.state = pacc_pkg::pacc_idle;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cal_hold  = (s.state == pacc_pkg::pacc_hold);
    assign cal_start = s.start;
    assign busy      = (s.state == pacc_pkg::pacc_run);
    assign done      = s.done;
    assign res_cap   = s.cap;
    assign res_cur   = s.cur;
    assign res_gain  = s.gain;

endmodule

// File: src/pacc_top.sv
`timescale 1ns/1ps
module pacc_top #(
    parameter int CAP_W  = 6,
    parameter int CUR_W  = 2,
    parameter int GAIN_W = 4
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // avalon-mm slave, byte addressed
    input  wire logic [pacc_pkg::ADDR_W-1:0] address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [31:0]                 writedata,
    input  wire logic [3:0]                  byteenable,
    output logic [31:0]                      readdata,
    output logic                             waitrequest,
    // calibration engine
    input  wire logic                        cal_done,
    input  wire logic [CAP_W-1:0]            cal_cap_result,
    input  wire logic [CUR_W-1:0]            cal_current_result,
    input  wire logic [GAIN_W-1:0]           cal_gain_result,
    output logic                             cal_hold,
    output logic                             cal_start,
    // applied amplifier settings
    output logic [CAP_W-1:0]                 tune_cap,
    output logic [CUR_W-1:0]                 amp_current_select,
    output logic [GAIN_W-1:0]                gain_step,
    // applied settings in physical units
    output logic [14:0]                      tune_cap_ff,
    output logic [11:0]                      amp_current_ua,
    output logic [15:0]                      output_level_cdbuv
);

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    // the fields share one byte with their control bits
    generate
        if (CAP_W < 1 || CAP_W > 6) begin : g_bad_cap
            $error("tuning capacitor width must be 1 to 6");
        end
        if (CUR_W != 2) begin : g_bad_cur
            $error("current select width must be 2");
        end
        if (GAIN_W < 1 || GAIN_W > 4) begin : g_bad_gain
            $error("gain step width must be 1 to 4");
        end
    endgenerate

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic              cap_req;
        logic              cap_dis;
        logic [CAP_W-1:0]  user_cap;
        logic              pow_dis;
        logic [CUR_W-1:0]  user_cur;
        logic [GAIN_W-1:0] user_gain;
        logic [CAP_W-1:0]  cap;
        logic [CUR_W-1:0]  cur;
        logic [GAIN_W-1:0] gain;
        logic [14:0]       cap_ff;
        logic [11:0]       cur_ua;
        logic [15:0]       level;
    } pacc_top_st_type;

    pacc_top_st_type   s;
    pacc_top_st_type   next_s;

    // ----------------------------------------
    // sequencer wiring
    // ----------------------------------------
    logic              seq_busy;
    logic              seq_done;
    logic [CAP_W-1:0]  res_cap;
    logic [CUR_W-1:0]  res_cur;
    logic [GAIN_W-1:0] res_gain;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    logic [7:0]        idx;
    logic              aligned;
    logic              req_any;
    logic              take;
    logic              wr_lane0;
    logic [7:0]        wbyte;
    logic [7:0]        rd_cap;
    logic [7:0]        rd_pow;
    logic [7:0]        rd_stat;
    logic [CAP_W-1:0]  pick_cap;
    logic [CUR_W-1:0]  pick_cur;
    logic [GAIN_W-1:0] pick_gain;

    pacc_cal_seq #(
        .CAP_W  (CAP_W),
        .CUR_W  (CUR_W),
        .GAIN_W (GAIN_W)
    ) u_seq (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .req                (s.cap_req),
        .cal_done           (cal_done),
        .cal_cap_result     (cal_cap_result),
        .cal_current_result (cal_current_result),
        .cal_gain_result    (cal_gain_result),
        .cal_hold           (cal_hold),
        .cal_start          (cal_start),
        .busy               (seq_busy),
        .done               (seq_done),
        .res_cap            (res_cap),
        .res_cur            (res_cur),
        .res_gain           (res_gain)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // one wait cycle: read data is registered before the ack cycle
    assign idx      = 8'(address[pacc_pkg::ADDR_W-1:2]);
    assign aligned  = (address[1:0] == 2'h0);
    assign req_any  = read | write;
    assign take     = req_any & s.ack;
    assign wr_lane0 = write & take & byteenable[0] & aligned;
    assign wbyte    = writedata[7:0];

    // ----------------------------------------
    // read views
    // ----------------------------------------
    // control bits are write-only and read back as zero
    always_comb begin
        rd_cap = 8'h00;
        rd_cap[CAP_W-1:0] = res_cap;
        rd_pow = 8'h00;
        rd_pow[pacc_pkg::CUR_LSB +: CUR_W] = res_cur;
        rd_pow[pacc_pkg::GAIN_LSB +: GAIN_W] = res_gain;
        rd_stat = 8'h00;
        rd_stat[pacc_pkg::STAT_BUSY] = seq_busy;
        rd_stat[pacc_pkg::STAT_DONE] = seq_done;
        rd_stat[pacc_pkg::STAT_HOLD] = cal_hold;
    end

    // ----------------------------------------
    // setting selection
    // ----------------------------------------
    always_comb begin
        pick_cap  = s.cap_dis ? s.user_cap : res_cap;
        pick_cur  = s.pow_dis ? s.user_cur : res_cur;
        pick_gain = s.pow_dis ? s.user_gain : res_gain;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;

        // ack pulses for one cycle per request, then drops for the release
        next_s.ack = req_any & ~s.ack;

        // unmapped or misaligned reads return zero
        next_s.rdata = 32'h0000_0000;
        if (read && aligned) begin
            unique case (idx)
                pacc_pkg::IDX_CAP:  next_s.rdata = {24'h00_0000, rd_cap};
                pacc_pkg::IDX_POW:  next_s.rdata = {24'h00_0000, rd_pow};
                pacc_pkg::IDX_STAT: next_s.rdata = {24'h00_0000, rd_stat};
                default:            next_s.rdata = 32'h0000_0000;
            endcase
        end

        // writes land at the edge where waitrequest is low
        if (wr_lane0) begin
            unique case (idx)
                pacc_pkg::IDX_CAP: begin
                    next_s.cap_req  = wbyte[pacc_pkg::CAP_REQ_BIT];
                    next_s.cap_dis  = wbyte[pacc_pkg::CAP_DIS_BIT];
                    next_s.user_cap = wbyte[CAP_W-1:0];
                end
                pacc_pkg::IDX_POW: begin
                    next_s.pow_dis   = wbyte[pacc_pkg::POW_DIS_BIT];
                    next_s.user_cur  = wbyte[pacc_pkg::CUR_LSB +: CUR_W];
                    next_s.user_gain = wbyte[pacc_pkg::GAIN_LSB +: GAIN_W];
                end
                default: begin
                    next_s.cap_req = s.cap_req;
                end
            endcase
        end

        // applied codes, registered so the analogue side sees no glitches
        next_s.cap  = pick_cap;
        next_s.cur  = pick_cur;
        next_s.gain = pick_gain;

        // physical units follow the applied codes one cycle later
        next_s.cap_ff = 15'(15'(s.cap) * 15'(pacc_pkg::CAP_STEP_FF));
        unique case (2'(s.cur))
            2'h0: next_s.cur_ua = pacc_pkg::CUR_UA_0;
            2'h1: next_s.cur_ua = pacc_pkg::CUR_UA_1;
            2'h2: next_s.cur_ua = pacc_pkg::CUR_UA_2;
            2'h3: next_s.cur_ua = pacc_pkg::CUR_UA_3;
        endcase
        next_s.level = 16'(pacc_pkg::LEVEL_TOP
                         - 16'(16'(s.gain) * pacc_pkg::LEVEL_STEP));
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s          <= '0;
            s.cap_req  <= pacc_pkg::CAP_RST[pacc_pkg::CAP_REQ_BIT];
            s.cap_dis  <= pacc_pkg::CAP_RST[pacc_pkg::CAP_DIS_BIT];
            s.user_cap <= pacc_pkg::CAP_RST[CAP_W-1:0];
            s.pow_dis  <= pacc_pkg::POW_RST[pacc_pkg::POW_DIS_BIT];
            s.user_cur <= pacc_pkg::POW_RST[pacc_pkg::CUR_LSB +: CUR_W];
            s.user_gain <= pacc_pkg::POW_RST[pacc_pkg::GAIN_LSB +: GAIN_W];
            s.cur_ua   <= pacc_pkg::CUR_UA_0;
            s.level    <= pacc_pkg::LEVEL_TOP;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign waitrequest        = req_any & ~s.ack;
    assign readdata           = s.rdata;
    assign tune_cap           = s.cap;
    assign amp_current_select = s.cur;
    assign gain_step          = s.gain;
    assign tune_cap_ff        = s.cap_ff;
    assign amp_current_ua     = s.cur_ua;
    assign output_level_cdbuv = s.level;

endmodule

// File: tb/pacc_top_sva.sv
`timescale 1ns/1ps
module pacc_top_sva #(
    parameter int CAP_W  = 6,
    parameter int CUR_W  = 2,
    parameter int GAIN_W = 4
) (
    // clock and reset
    input wire logic                        mclk,
    input wire logic                        rst_n,
    // register bus
    input wire logic [pacc_pkg::ADDR_W-1:0] address,
    input wire logic                        read,
    input wire logic                        write,
    input wire logic [31:0]                 readdata,
    input wire logic                        waitrequest,
    // calibration control
    input wire logic                        cal_hold,
    input wire logic                        cal_start,
    // applied settings
    input wire logic [CAP_W-1:0]            tune_cap,
    input wire logic [CUR_W-1:0]            amp_current_select,
    input wire logic [GAIN_W-1:0]           gain_step,
    input wire logic [14:0]                 tune_cap_ff,
    input wire logic [11:0]                 amp_current_ua,
    input wire logic [15:0]                 output_level_cdbuv
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest without a request");
    a_one_wait: assert property ((read || write) && waitrequest ##1 (read || write) |-> !waitrequest)
        else $error("request not answered after one wait cycle");
    a_unmapped_zero: assert property (read && !waitrequest && (address[1:0] != 2'b00
        || !(address[9:2] inside {8'h59, 8'h5A, 8'h5B})) |-> readdata == 32'h0)
        else $error("unmapped read returned data");
    a_hold_nostart: assert property (cal_hold |-> !cal_start)
        else $error("start pulse while held");
    a_start_cause: assert property ($rose(cal_start) |-> $past(cal_hold))
        else $error("start without preceding hold");
    a_start_pulse: assert property (cal_start |=> !cal_start)
        else $error("start pulse longer than one cycle");
    a_cap_units: assert property (tune_cap_ff == 15'($past(tune_cap)) * 15'h12C)
        else $error("capacitance units wrong");
    a_cur_units: assert property (amp_current_ua == (12'hFA0 >> $past(amp_current_select)))
        else $error("current units wrong");
    a_level_units: assert property
        (output_level_cdbuv == 16'h3070 - 16'h0096 * 16'($past(gain_step)))
        else $error("output level wrong");
endmodule

bind pacc_top pacc_top_sva #(.CAP_W(CAP_W), .CUR_W(CUR_W), .GAIN_W(GAIN_W)) u_sva (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .cal_hold(cal_hold),
    .cal_start(cal_start), .tune_cap(tune_cap), .amp_current_select(amp_current_select),
    .gain_step(gain_step), .tune_cap_ff(tune_cap_ff), .amp_current_ua(amp_current_ua),
    .output_level_cdbuv(output_level_cdbuv));

// File: tb/test_pa_calibration_control.sv
`timescale 1ns/1ps
module test_pa_calibration_control;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, cal_done = 1'b0;
    logic [9:0]  address = 10'h000;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0]  byteenable = 4'hF, cal_gain_result = 4'h0, gain_step;
    logic [5:0]  cal_cap_result = 6'h00, tune_cap;
    logic [1:0]  cal_current_result = 2'h0, amp_current_select;
    logic        waitrequest, cal_hold, cal_start;
    logic [14:0] tune_cap_ff;
    logic [11:0] amp_current_ua;
    logic [15:0] output_level_cdbuv;
    int          n_errors = 0, checks_done = 0;
    integer      seed = 32'hAC8B;
    localparam logic [9:0] A_CAP  = {pacc_pkg::IDX_CAP, 2'b00};
    localparam logic [9:0] A_POW  = {pacc_pkg::IDX_POW, 2'b00};
    localparam logic [9:0] A_STAT = {pacc_pkg::IDX_STAT, 2'b00};

    pacc_top uut (
        .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .cal_done(cal_done), .cal_cap_result(cal_cap_result),
        .cal_current_result(cal_current_result), .cal_gain_result(cal_gain_result),
        .cal_hold(cal_hold), .cal_start(cal_start), .tune_cap(tune_cap),
        .amp_current_select(amp_current_select), .gain_step(gain_step),
        .tune_cap_ff(tune_cap_ff), .amp_current_ua(amp_current_ua),
        .output_level_cdbuv(output_level_cdbuv));

    always #5 mclk = ~mclk;

    // ----------------------------------------
    // shared tasks and expectations
    // ----------------------------------------
    task automatic final_report();
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // upper write lanes carry noise: only the low byte may matter
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        address    <= a;
        read       <= ~wr;
        write      <= wr;
        writedata  <= {24'($random(seed)), d};
        byteenable <= be;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            n_errors++;
            final_report();
        end
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hF, q);
        check(q, exp);
    endtask

    function automatic logic [14:0] exp_ff(input logic [5:0] c);
        return 15'(c) * 15'h12C;
    endfunction
    function automatic logic [11:0] exp_ua(input logic [1:0] c);
        return 12'hFA0 >> c;
    endfunction
    function automatic logic [15:0] exp_lvl(input logic [3:0] g);
        return 16'h3070 - 16'h0096 * 16'(g);
    endfunction

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [5:0]  ucap, rcap, acap;
        logic [1:0]  ucur, rcur, acur;
        logic [3:0]  ugain, rgain, again;
        logic [31:0] q;
        logic        d;
        int          n;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(A_CAP, 32'h0);
        rd_chk(A_POW, 32'h0);
        rd_chk(A_STAT, 32'h0);
        rd_chk(10'h170, 32'h0);
        rd_chk(10'h165, 32'h0);
        // every current code is applied once from each source
        for (int i = 0; i < 8; i++) begin
            d     = i[2];
            ucur  = i[1:0];
            rcur  = ~ucur;
            ucap  = 6'($random(seed));
            rcap  = 6'($random(seed));
            ugain = (i == 7) ? 4'hF : 4'($random(seed));
            rgain = (i == 0) ? 4'hF : 4'($random(seed));
            wr(A_POW, {1'b0, d, ucur, ugain});
            bus(1'b1, A_POW, ~{1'b0, d, ucur, ugain}, 4'hE, q);
            wr(A_CAP, {1'b1, d, ucap});
            cal_done       <= 1'b1;
            cal_cap_result <= ~rcap;
            repeat (2) @(posedge mclk);
            check(cal_hold, 1'b1);
            cal_done <= 1'b0;
            wr(A_CAP, {1'b0, d, ucap});
            n = 0;
            while (cal_start !== 1'b1 && n < 10) begin
                @(posedge mclk);
                n++;
            end
            check(n, 2);
            if (n >= 10) final_report();
            cal_done           <= 1'b1;
            cal_cap_result     <= rcap;
            cal_current_result <= rcur;
            cal_gain_result    <= rgain;
            @(posedge mclk);
            cal_done           <= 1'b0;
            cal_cap_result     <= ~rcap;
            cal_current_result <= ucur;
            cal_gain_result    <= ~rgain;
            repeat (3) @(posedge mclk);
            rd_chk(A_STAT, 32'h2);
            rd_chk(A_CAP, {26'h0, rcap});
            rd_chk(A_POW, {26'h0, rcur, rgain});
            acap  = d ? ucap : rcap;
            acur  = d ? ucur : rcur;
            again = d ? ugain : rgain;
            check(tune_cap, acap);
            check({amp_current_select, gain_step}, {acur, again});
            check(tune_cap_ff, exp_ff(acap));
            check(amp_current_ua, exp_ua(acur));
            check(output_level_cdbuv, exp_lvl(again));
        end
        // misaligned and unmapped writes must not reach the request bit
        bus(1'b1, A_CAP | 10'h001, 8'h80, 4'hF, q);
        bus(1'b1, 10'h170, 8'h80, 4'hF, q);
        repeat (2) @(posedge mclk);
        check(cal_hold, 1'b0);
        check(tune_cap, ucap);
        // reset after the last run: results and applied settings fall back to defaults
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check({cal_hold, cal_start}, 2'b00);
        check({tune_cap, tune_cap_ff}, {6'h00, exp_ff(6'h00)});
        check(amp_current_ua, exp_ua(2'h0));
        check(output_level_cdbuv, exp_lvl(4'h0));
        rd_chk(A_CAP, 32'h0);
        rd_chk(A_POW, 32'h0);
        rd_chk(A_STAT, 32'h0);
        final_report();
    end
endmodule
